/* File: pkg/mft_pkg.sv */
// Contract
// - free running wraps through all ones or zero with no end of count or reload
// - free running is chosen by bicapture, or by continuous mode with capture on first
// - second register mirrors live counter when its capture select and bivalue are off
// - a clear sets the counter to zero counting up, all ones counting down
// - the direct clear bit clears the counter at once, whatever the autoclear setting
// - clear on capture or on compare zero match clears counter and reloads prescaler
// - with bivalue set, first capture select 0 is biload and 1 is bicapture
// - biload reloads alternately from first and second; bivalue low resets to first
// - a first-register trigger in biload reloads from first; one shot uses first only
// - bicapture stores captures alternately, starting with the first register
// - with cascade set the prescaler is fed from the neighbour prescaler output; the code lets a pin A or pin B external clock take precedence
// - prescaler value zero passes every input tick, so cascaded division spans 1 to 2^16
// - autodiscrimination makes single up or down steps; software direction is ignored
// - each pin has a two-bit edge selection: none, rising, falling or both
// - a four-bit function code selects one of sixteen pin pairings
// - a pin A trigger loads when first capture select is clear, else captures
// - a pin B trigger captures into the second register; ignored under bivalue
// - with pin A as gate the internal clock counts only while pin A is low
// - with both pins unused the clock is internal and direction is the software bit
// - pin B as external clock feeds the prescaler, gated by pin A when so set
// - software trigger flags act exactly like the matching pin triggers
// - continuous mode reloads at end of count from first, or alternately from first and second in biload
package mft_pkg;
   localparam int MFT_AW = 6;
   localparam logic [MFT_AW-1:0] OFF_MODE = 6'h00;
   localparam logic [MFT_AW-1:0] OFF_CTRL = 6'h04;
   localparam logic [MFT_AW-1:0] OFF_ICR = 6'h08;
   localparam logic [MFT_AW-1:0] OFF_FLAG = 6'h0C;
   localparam logic [MFT_AW-1:0] OFF_PRESC = 6'h10;
   localparam logic [MFT_AW-1:0] OFF_REG0 = 6'h14;
   localparam logic [MFT_AW-1:0] OFF_REG1 = 6'h18;
   localparam logic [MFT_AW-1:0] OFF_CMP0 = 6'h1C;
   localparam logic [MFT_AW-1:0] OFF_CNT = 6'h20;
   localparam logic [MFT_AW-1:0] OFF_STAT = 6'h24;
   // timer_mode_reg fields
   localparam int MODE_ONESHOT = 0;
   localparam int MODE_RM0 = 1;
   localparam int MODE_RM1 = 2;
   localparam int MODE_BM = 3;
   localparam int MODE_ECK = 4;
   // timer_control_reg fields
   localparam int CTRL_CEN = 0;
   localparam int CTRL_UDC = 1;
   localparam int CTRL_CLEAR_ON_CAPTURE = 2;
   localparam int CTRL_CLEAR_ON_COMPARE = 3;
   localparam int CTRL_CCL = 4;
   // input_control_reg fields
   localparam int ICR_FN_LSB = 0;
   localparam int ICR_AE_LSB = 4;
   localparam int ICR_BE_LSB = 6;
   // timer_flag_reg fields
   localparam int FLAG_CP0 = 0;
   localparam int FLAG_CP1 = 1;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam logic [7:0] ICR_RST = 8'h00;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam logic [1:0] PRE_DIV_LAST = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } mft_edge_t;
   typedef enum logic [3:0] {
      FN_IO_IO = 4'b0000,
      FN_IO_TRIG = 4'b0001,
      FN_GATE_IO = 4'b0010,
      FN_GATE_TRIG = 4'b0011,
      FN_IO_EXT = 4'b0100,
      FN_TRIG_IO = 4'b0101,
      FN_GATE_EXT = 4'b0110,
      FN_TRIG_TRIG = 4'b0111,
      FN_CLK_UPDN = 4'b1000,
      FN_UD_EXT = 4'b1001,
      FN_TRUP_TRDN = 4'b1010,
      FN_UD_IO = 4'b1011,
      FN_AUTOD = 4'b1100,
      FN_TRIG_EXT = 4'b1101,
      FN_EXT_TRIG = 4'b1110,
      FN_TRIG_GATE = 4'b1111
   } mft_fn_t;
endpackage : mft_pkg

/* File: pkg/mft_pin_if.sv */
`timescale 1ns/1ps
interface mft_pin_if;
   logic lvl;
   logic rise;
   logic fall;
   logic evt;
   modport drv (output lvl, output rise, output fall, output evt);
   modport mon (input lvl, input rise, input fall, input evt);
endinterface : mft_pin_if

/* File: design/mft_pin_cond.sv */
`timescale 1ns/1ps
module mft_pin_cond (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pin and its edge choice
   input wire logic pin_raw,
   input wire logic [1:0] edge_sel,
   // conditioned view
   mft_pin_if.drv pin
);
   import mft_pkg::*;
   logic s1_r;
   logic s2_r;
   logic s3_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign pin.lvl = s2_r;
   assign pin.rise = s2_r & ~s3_r;
   assign pin.fall = ~s2_r & s3_r;
   assign pin.evt = (pin.rise & edge_sel[0]) | (pin.fall & edge_sel[1]);

   chk_sync_rise_delay: assert property (@(posedge clk) disable iff (!rst_n)
      pin.rise |-> $past(pin_raw, 2) && !$past(pin_raw, 3))
      else $error("rise seen without a two-stage delayed edge");
   chk_edge_none_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      (edge_sel == EDGE_NONE) |-> !pin.evt)
      else $error("edge event while no edge selected");
endmodule : mft_pin_cond

/* File: design/mft_timer.sv */
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module mft_timer #(
   parameter int CW = 16,
   parameter int PW = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // axi4-lite write
   input wire logic [mft_pkg::MFT_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [mft_pkg::MFT_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timer pins and cascade
   input wire logic input_pin_a,
   input wire logic input_pin_b,
   input wire logic casc_tick_in,
   output logic presc_tick_out,
   output logic eoc_out
);
   import mft_pkg::*;

   // bus slave state
   logic aw_free_r;
   logic w_free_r;
   logic ar_free_r;
   logic bvalid_r;
   logic rvalid_r;
   logic [1:0] bresp_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic [MFT_AW-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   // registers
   logic [7:0] timer_mode_reg_r;
   logic [7:0] timer_control_reg_r;
   logic [7:0] input_control_reg_r;
   logic [PW-1:0] presc_val_r;
   logic [CW-1:0] first_value_register_r;
   logic [CW-1:0] second_value_register_r;
   logic [CW-1:0] compare_zero_register_r;
   // core state
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [PW-1:0] pcnt_r;
   logic [1:0] div_r;
   logic dir_up_r;
   logic bisel_r;
   logic bisel_nxt;
   logic run_r;
   logic run_nxt;
   logic [CW-1:0] r0_nxt;
   logic [CW-1:0] r1_nxt;
   logic pre_clr;
   logic eoc_nxt;
   logic presc_tick_r;
   logic eoc_r;

   mft_pin_if pa();
   mft_pin_if pb();

   mft_pin_cond u_pin_a (
      .clk(clk),
      .rst_n(rst_n),
      .pin_raw(input_pin_a),
      .edge_sel(input_control_reg_r[ICR_AE_LSB +: 2]),
      .pin(pa)
   );
   mft_pin_cond u_pin_b (
      .clk(clk),
      .rst_n(rst_n),
      .pin_raw(input_pin_b),
      .edge_sel(input_control_reg_r[ICR_BE_LSB +: 2]),
      .pin(pb)
   );

   function automatic logic [CW-1:0] merge_w(input logic [CW-1:0] old,
                                             input logic [31:0] d, input logic [3:0] s);
      logic [CW-1:0] r;
      r = old;
      for (int i = 0; i < CW / 8; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_w

   // bus decode
   wire wr_en = ~aw_free_r & ~w_free_r & ~bvalid_r;
   wire wr_l0 = wr_en & wstrb_r[0];
   wire sel_mode = wr_l0 && (awaddr_r == OFF_MODE);
   wire sel_ctrl = wr_l0 && (awaddr_r == OFF_CTRL);
   wire sel_icr = wr_l0 && (awaddr_r == OFF_ICR);
   wire sel_flag = wr_l0 && (awaddr_r == OFF_FLAG);
   wire sel_presc = wr_l0 && (awaddr_r == OFF_PRESC);
   wire sel_r0 = wr_en && (awaddr_r == OFF_REG0);
   wire sel_r1 = wr_en && (awaddr_r == OFF_REG1);
   wire sel_cmp = wr_en && (awaddr_r == OFF_CMP0);
   wire wr_hit = (awaddr_r == OFF_MODE) || (awaddr_r == OFF_CTRL) ||
                 (awaddr_r == OFF_ICR) || (awaddr_r == OFF_FLAG) ||
                 (awaddr_r == OFF_PRESC) || (awaddr_r == OFF_REG0) ||
                 (awaddr_r == OFF_REG1) || (awaddr_r == OFF_CMP0);
   wire rd_take = s_axi_arvalid & ar_free_r;
   wire [31:0] zx = 32'h0;
   wire [31:0] rd_val =
      (s_axi_araddr == OFF_MODE) ? {zx[31:8], timer_mode_reg_r} :
      (s_axi_araddr == OFF_CTRL) ? {zx[31:8], timer_control_reg_r} :
      (s_axi_araddr == OFF_ICR) ? {zx[31:8], input_control_reg_r} :
      (s_axi_araddr == OFF_FLAG) ? zx :
      (s_axi_araddr == OFF_PRESC) ? {zx[31:PW], presc_val_r} :
      (s_axi_araddr == OFF_REG0) ? {zx[31:CW], first_value_register_r} :
      (s_axi_araddr == OFF_REG1) ? {zx[31:CW], second_value_register_r} :
      (s_axi_araddr == OFF_CMP0) ? {zx[31:CW], compare_zero_register_r} :
      (s_axi_araddr == OFF_CNT) ? {zx[31:CW], cnt_r} :
      {zx[31:3], bisel_r, run_r, dir_up_r};
   wire rd_hit = (s_axi_araddr <= OFF_STAT) && (s_axi_araddr[1:0] == 2'h0);

   // mode and control fields
   wire oneshot = timer_mode_reg_r[MODE_ONESHOT];
   wire rm0 = timer_mode_reg_r[MODE_RM0];
   wire rm1 = timer_mode_reg_r[MODE_RM1];
   wire bm = timer_mode_reg_r[MODE_BM];
   wire cascade_enable = timer_mode_reg_r[MODE_ECK];
   wire cen = timer_control_reg_r[CTRL_CEN];
   wire software_direction_bit = timer_control_reg_r[CTRL_UDC];
   wire clear_on_capture = timer_control_reg_r[CTRL_CLEAR_ON_CAPTURE];
   wire clear_on_compare = timer_control_reg_r[CTRL_CLEAR_ON_COMPARE];
   wire ccl_wr = sel_ctrl & wdata_r[CTRL_CCL];
   wire biload = bm & ~rm0;
   wire bicap = bm & rm0;
   wire freerun = bicap | (~oneshot & rm0);

   // pin function decode
   mft_fn_t fn;
   assign fn = mft_fn_t'(input_control_reg_r[ICR_FN_LSB +: 4]);
   wire a_gate = (fn == FN_GATE_IO) || (fn == FN_GATE_TRIG) || (fn == FN_GATE_EXT);
   wire b_gate = (fn == FN_TRIG_GATE);
   wire a_trig = (fn == FN_TRIG_IO) || (fn == FN_TRIG_TRIG) ||
                 (fn == FN_TRIG_EXT) || (fn == FN_TRIG_GATE);
   wire b_trig = (fn == FN_IO_TRIG) || (fn == FN_GATE_TRIG) ||
                 (fn == FN_TRIG_TRIG) || (fn == FN_EXT_TRIG);
   wire b_ext = (fn == FN_IO_EXT) || (fn == FN_GATE_EXT) ||
                (fn == FN_UD_EXT) || (fn == FN_TRIG_EXT);
   wire a_ext = (fn == FN_EXT_TRIG);
   wire direct = (fn == FN_CLK_UPDN) || (fn == FN_AUTOD);
   wire a_ud = (fn == FN_UD_EXT) || (fn == FN_UD_IO);

   // prescaler source and gating
   wire div_tick = (div_r == PRE_DIV_LAST);
   wire int_src = cascade_enable ? casc_tick_in : div_tick;
   wire src = b_ext ? pb.evt : (a_ext ? pa.evt : int_src);
   wire gate_open = ~(a_gate & pa.lvl) & ~(b_gate & pb.lvl);
   wire presc_in = src & gate_open & cen & run_r;
   wire ptick = presc_in && (pcnt_r == '0);

   // direct stepping: clock up/down pair and autodiscrimination
   wire dstep_dn = (fn == FN_CLK_UPDN) ? pb.evt : (pb.fall & ~pa.lvl);
   wire dstep_up = (fn == FN_CLK_UPDN) ? (pa.evt & ~pb.evt) : (pb.rise & ~pa.lvl);
   wire dir_trig = pb.evt ? 1'b0 : (pa.evt ? 1'b1 : dir_up_r);
   wire dir_up_nxt = direct ? (dstep_up | (~dstep_dn & dir_up_r)) :
                     a_ud ? pa.lvl :
                     (fn == FN_TRUP_TRDN) ? dir_trig : software_direction_bit;
   wire step = cen & run_r & (direct ? (dstep_up | dstep_dn) : ptick);
   wire at_end = dir_up_nxt ? (cnt_r == '1) : (cnt_r == '0);
   wire cmp_clr = clear_on_compare && (cnt_r == compare_zero_register_r);
   wire [CW-1:0] clr_val = dir_up_nxt ? '0 : '1;

   // triggers, software flags behave like the pins
   wire sw_cp0 = sel_flag & wdata_r[FLAG_CP0];
   wire sw_cp1 = sel_flag & wdata_r[FLAG_CP1];
   wire trig_a = (a_trig & pa.evt) | sw_cp0;
   wire trig_b = ((b_trig & pb.evt) | sw_cp1) & ~bm;

   always_comb begin
      cnt_nxt = cnt_r;
      r0_nxt = sel_r0 ? merge_w(first_value_register_r, wdata_r, wstrb_r) :
               first_value_register_r;
      r1_nxt = sel_r1 ? merge_w(second_value_register_r, wdata_r, wstrb_r) :
               second_value_register_r;
      bisel_nxt = bisel_r;
      run_nxt = run_r;
      pre_clr = 1'b0;
      eoc_nxt = 1'b0;
      if (step) begin
         if (cmp_clr) begin
            cnt_nxt = clr_val;
            pre_clr = 1'b1;
         end else if (at_end & ~freerun) begin
            eoc_nxt = 1'b1;
            if (oneshot) begin
               run_nxt = 1'b0;
            end else begin
               cnt_nxt = (biload & bisel_r) ? second_value_register_r :
                         first_value_register_r;
               bisel_nxt = biload & ~bisel_r;
            end
         end else begin
            cnt_nxt = dir_up_nxt ? cnt_r + 1'b1 : cnt_r - 1'b1;
         end
      end
      // pin B first so that a same-cycle pin A action lands last
      if (trig_b) begin
         r1_nxt = cnt_r;
      end
      if (trig_a) begin
         if (!rm0) begin
            cnt_nxt = first_value_register_r;
            run_nxt = 1'b1;
            bisel_nxt = biload & ~oneshot;
         end else begin
            if (bicap & bisel_r) begin
               r1_nxt = cnt_r;
            end else begin
               r0_nxt = cnt_r;
               if (clear_on_capture) begin
                  cnt_nxt = clr_val;
                  pre_clr = 1'b1;
               end
            end
            bisel_nxt = bicap & ~bisel_r;
         end
      end
      if (!bm) begin
         bisel_nxt = 1'b0;
      end
      if (ccl_wr) begin
         cnt_nxt = clr_val;
         pre_clr = 1'b1;
      end
      if (!rm1 && !bm) begin
         r1_nxt = cnt_nxt;
      end
   end

   // bus slave
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_free_r <= 1'b1;
         w_free_r <= 1'b1;
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid & aw_free_r) begin
            aw_free_r <= 1'b0;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_en) begin
            aw_free_r <= 1'b1;
         end
         if (s_axi_wvalid & w_free_r) begin
            w_free_r <= 1'b0;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_en) begin
            w_free_r <= 1'b1;
         end
         if (wr_en) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ar_free_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= RESP_OKAY;
      end else if (rd_take) begin
         ar_free_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_hit ? rd_val : 32'h0;
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r & s_axi_rready) begin
         ar_free_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_mode_reg_r <= MODE_RST;
         timer_control_reg_r <= CTRL_RST;
         input_control_reg_r <= ICR_RST;
         presc_val_r <= PRESC_RST[PW-1:0];
         compare_zero_register_r <= '0;
      end else begin
         if (sel_mode) timer_mode_reg_r <= wdata_r[7:0];
         if (sel_ctrl) timer_control_reg_r <= {4'h0, wdata_r[3:0]};
         if (sel_icr) input_control_reg_r <= wdata_r[7:0];
         if (sel_presc) presc_val_r <= wdata_r[PW-1:0];
         if (sel_cmp) begin
            compare_zero_register_r <= merge_w(compare_zero_register_r, wdata_r, wstrb_r);
         end
      end
   end

   // counter core
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         first_value_register_r <= '0;
         second_value_register_r <= '0;
         dir_up_r <= 1'b1;
         bisel_r <= 1'b0;
         run_r <= 1'b1;
         eoc_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         first_value_register_r <= r0_nxt;
         second_value_register_r <= r1_nxt;
         dir_up_r <= dir_up_nxt;
         bisel_r <= bisel_nxt;
         run_r <= run_nxt;
         eoc_r <= eoc_nxt;
      end
   end

   // divide by three base tick and prescaler
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 2'h0;
         pcnt_r <= '0;
         presc_tick_r <= 1'b0;
      end else begin
         div_r <= div_tick ? 2'h0 : div_r + 2'h1;
         if (pre_clr) begin
            pcnt_r <= presc_val_r;
         end else if (presc_in) begin
            pcnt_r <= ptick ? presc_val_r : pcnt_r - 1'b1;
         end
         presc_tick_r <= ptick;
      end
   end

   assign s_axi_awready = aw_free_r;
   assign s_axi_wready = w_free_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = ar_free_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign presc_tick_out = presc_tick_r;
   assign eoc_out = eoc_r;

   // checks
   chk_ccl_clear: assert property (@(posedge clk) disable iff (!rst_n)
      ccl_wr |=> cnt_r == ($past(dir_up_nxt) ? '0 : '1))
      else $error("direct clear did not reach the clear value");
   chk_monitor_mirror: assert property (@(posedge clk) disable iff (!rst_n)
      (!rm1 && !bm) |=> second_value_register_r == cnt_r)
      else $error("second register not mirroring counter");
   chk_bisel_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !bm |=> !bisel_r)
      else $error("alternation not reset while bivalue low");
   chk_gate_stop: assert property (@(posedge clk) disable iff (!rst_n)
      (a_gate && pa.lvl && !pre_clr) |-> !presc_in ##1 $stable(pcnt_r))
      else $error("prescaler moved while gate high");
   chk_free_wrap: assert property (@(posedge clk) disable iff (!rst_n)
      (step && freerun && dir_up_nxt && cnt_r == '1 && !cmp_clr && !trig_a && !ccl_wr)
      |=> cnt_r == '0 && !eoc_r)
      else $error("free running did not wrap cleanly");
   chk_biload_alt: assert property (@(posedge clk) disable iff (!rst_n)
      (step && at_end && biload && !oneshot && !freerun && !cmp_clr && !trig_a && !ccl_wr)
      |=> bisel_r != $past(bisel_r) && eoc_r)
      else $error("biload did not alternate at end of count");
   cov_biload_reload: cover property (@(posedge clk) disable iff (!rst_n)
      biload && eoc_nxt && bisel_r);
   cov_bicap_second: cover property (@(posedge clk) disable iff (!rst_n)
      bicap && trig_a && bisel_r);
   cov_autod_step: cover property (@(posedge clk) disable iff (!rst_n)
      (fn == FN_AUTOD) && step && !dir_up_nxt);
endmodule : mft_timer

/* File: dv/mft_pin_src.sv */
`timescale 1ns/1ps
module mft_pin_src (
   // clock
   input wire logic clk,
   // driven pins
   output logic pin_a,
   output logic pin_b
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // six-clock phases stay clear of the minimum pulse and gap widths
   task automatic pulse(input logic on_b);
      repeat (6) @(posedge clk);
      if (on_b) pin_b <= 1'b1;
      else pin_a <= 1'b1;
      repeat (6) @(posedge clk);
      if (on_b) pin_b <= 1'b0;
      else pin_a <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : pulse
   // gate level, held far longer than two prescaler periods
   task automatic set_a(input logic v);
      @(posedge clk);
      pin_a <= v;
   endtask : set_a
endmodule : mft_pin_src

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm_, ev, gv) \
   cmp_count++; \
   if ((gv) !== (ev)) begin \
      bad_count++; \
      $display("wrong value %s exp %h got %h", nm_, ev, gv); \
   end
module testbench;
   import mft_pkg::*;
   logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [MFT_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, rd2;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic input_pin_a, input_pin_b, casc_tick_in, presc_tick_out, eoc_out;
   logic [15:0] r0, r1, c1;
   int bad_count, cmp_count, seed, ptr, eoc_n, pt_n;
   int m_reg[2];
   mft_timer dut (.*);
   mft_pin_src src (.clk(clk), .pin_a(input_pin_a), .pin_b(input_pin_b));
   task automatic complete_run;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   task automatic tmo(input logic ok);
      if (ok !== 1'b1) begin
         bad_count++;
         complete_run();
      end
   endtask : tmo
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n;
      @(posedge clk);
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      s_axi_bready <= 1'b0;
      tmo(s_axi_bvalid);
      `CHK("bresp", er, s_axi_bresp)
   endtask : wr
   task automatic rdr(input logic [5:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n;
      @(posedge clk);
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      tmo(s_axi_rvalid);
      `CHK("rresp", er, s_axi_rresp)
   endtask : rdr
   task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
      logic [31:0] d;
      rdr(a, d);
      `CHK(nm, e, d)
   endtask : rchk
   always @(posedge clk) begin
      if (eoc_out === 1'b1) eoc_n <= eoc_n + 1;
      if (presc_tick_out === 1'b1) pt_n <= pt_n + 1;
   end
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      casc_tick_in = 1'b0;
      eoc_n = 0;
      seed = 32'h7d58;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rchk("icr_rst", OFF_ICR, {24'h0, ICR_RST});
      wr(6'h30, 32'h0, RESP_SLVERR);
      rdr(6'h30, rd, RESP_SLVERR);
      `CHK("unmapped", 32'h0, rd)
      // load through the soft trigger, then both clear directions
      r0 = $random(seed);
      r1 = $random(seed);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_REG0, {16'h0, r0});
      wr(OFF_FLAG, 32'h1);
      rchk("load", OFF_CNT, {16'h0, r0});
      rchk("mirror", OFF_REG1, {16'h0, r0});
      wr(OFF_CTRL, 32'h10);
      rchk("clr_dn", OFF_CNT, 32'hFFFF);
      wr(OFF_CTRL, 32'h02);
      wr(OFF_CTRL, 32'h12);
      rchk("clr_up", OFF_CNT, 32'h0);
      wr(OFF_MODE, 32'h02);
      wr(OFF_REG0, {16'h0, r1});
      wr(OFF_FLAG, 32'h1);
      rchk("capture", OFF_REG0, 32'h0);
      // alternating captures, soft and pin a, against the model
      wr(OFF_MODE, 32'h0A);
      wr(OFF_REG1, {16'h0, r1});
      wr(OFF_ICR, 32'h15);
      m_reg[0] = 0;
      m_reg[1] = r1;
      ptr = 0;
      for (int i = 0; i < 4; i++) begin
         c1 = (i == 0 || i == 3) ? 16'hFFFF : 16'h0;
         rd = (c1 == 16'h0) ? 32'h2 : 32'h0;
         wr(OFF_CTRL, rd);
         wr(OFF_CTRL, rd | 32'h10);
         if (i % 2 == 1) src.pulse(1'b0);
         else wr(OFF_FLAG, 32'h1);
         m_reg[ptr] = c1;
         ptr = 1 - ptr;
         rchk("bicap0", OFF_REG0, m_reg[0]);
         rchk("bicap1", OFF_REG1, m_reg[1]);
      end
      wr(OFF_FLAG, 32'h2);
      rchk("b_ignored", OFF_REG1, m_reg[1]);
      // pin b capture on its falling edge only
      wr(OFF_MODE, 32'h04);
      wr(OFF_REG0, {16'h0, r0});
      wr(OFF_FLAG, 32'h1);
      wr(OFF_ICR, 32'h01);
      src.pulse(1'b1);
      rchk("pin_b_none", OFF_REG1, m_reg[1]);
      wr(OFF_ICR, 32'h81);
      src.pulse(1'b1);
      rchk("pin_b_cap", OFF_REG1, {16'h0, r0});
      // gate on pin a
      wr(OFF_ICR, 32'h02);
      src.set_a(1'b1);
      wr(OFF_CTRL, 32'h03);
      rdr(OFF_CNT, rd);
      repeat (30) @(posedge clk);
      rchk("gated", OFF_CNT, rd);
      src.set_a(1'b0);
      repeat (30) @(posedge clk);
      rdr(OFF_CNT, rd2);
      `CHK("gate_open", 1'b1, rd2 != rd)
      // free running wraps from all ones without end of count
      wr(OFF_ICR, 32'h0);
      wr(OFF_MODE, 32'h02);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, 32'h10);
      ptr = eoc_n;
      wr(OFF_CTRL, 32'h03);
      repeat (6) @(posedge clk);
      rdr(OFF_CNT, rd);
      `CHK("wrap", 1'b1, rd < 32'h10)
      `CHK("no_eoc", 0, eoc_n - ptr)
      // clear on compare zero keeps the count at or below the compare value
      wr(OFF_CMP0, 32'h3);
      wr(OFF_CTRL, 32'h1B);
      repeat (40) @(posedge clk);
      rdr(OFF_CNT, rd);
      `CHK("cmp_clr", 1'b1, rd <= 32'h3)
      // biload: trigger loads first, the next end of count reloads second
      wr(OFF_CTRL, 32'h02);
      wr(OFF_MODE, 32'h08);
      wr(OFF_REG0, 32'hFFFE);
      wr(OFF_REG1, 32'h8000);
      wr(OFF_FLAG, 32'h1);
      ptr = eoc_n;
      wr(OFF_CTRL, 32'h03);
      repeat (30) @(posedge clk);
      rdr(OFF_CNT, rd);
      `CHK("biload", 4'h8, rd[15:12])
      `CHK("bi_eoc", 1, eoc_n - ptr)
      // cascade: each neighbour tick passes a zero prescaler and steps once
      wr(OFF_MODE, 32'h12);
      wr(OFF_CTRL, 32'h12);
      ptr = pt_n;
      wr(OFF_CTRL, 32'h03);
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         casc_tick_in <= 1'b1;
         @(posedge clk);
         casc_tick_in <= 1'b0;
      end
      rchk("cascade", OFF_CNT, 32'h5);
      `CHK("ptick", 5, pt_n - ptr)
      complete_run();
   end
endmodule : testbench
